// ---- rtl/fsdp_pkg.sv ----
package fsdp_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DATA_AI = 8'h04;
  localparam logic [7:0] REG_DATA_AQ = 8'h08;
  localparam logic [7:0] REG_DATA_BI = 8'h0C;
  localparam logic [7:0] REG_DATA_BQ = 8'h10;
  localparam logic [7:0] REG_FRAME_GO = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_STAGE_LO = 8'h1C;
  localparam logic [7:0] REG_STAGE_HI = 8'h20;
  localparam logic [7:0] REG_READBACK = 8'h24;

  // Control field positions and reset value
  localparam int CTRL_WL_LSB = 0;
  localparam int CTRL_DIV_BIT = 2;
  localparam int CTRL_SDIV_LSB = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  // Word length codes, last bit index and read limits
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_24 = 2'h1;
  localparam logic [1:0] WL_32 = 2'h2;
  localparam logic [5:0] WL_LAST_16 = 6'h0F;
  localparam logic [5:0] WL_LAST_24 = 6'h17;
  localparam logic [5:0] WL_LAST_32 = 6'h1F;
  localparam logic [2:0] RD_MAX_16 = 3'h2;
  localparam logic [2:0] RD_MAX_24 = 3'h3;
  localparam logic [2:0] RD_MAX_32 = 3'h4;

  // Command word layout
  localparam int CMD_READ_BIT = 15;
  localparam int CMD_WRITE_BIT = 14;
  localparam int CMD_ADDR_LSB = 8;
  localparam logic [5:0] CMD_BIT_READ = 6'h00;
  localparam logic [5:0] CMD_BIT_WRITE = 6'h01;
  localparam logic [5:0] CMD_BIT_LAST = 6'h0F;

  // I/Q words per frame
  localparam logic [2:0] IQ_WORDS_SINGLE = 3'h2;
  localparam logic [2:0] IQ_WORDS_DIV = 3'h4;

  // Serial clock limit and least half period in pclk cycles
  localparam int PCLK_KHZ = 200000;
  localparam int SCLK_MAX_KHZ = 32500;
  localparam int HALF_MIN_INT =
    (PCLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam logic [3:0] HALF_MIN = 4'(HALF_MIN_INT);

  // Strap capture delay after reset release
  localparam logic [1:0] STRAP_WAIT = 2'h2;

endpackage : fsdp_pkg

// ---- rtl/fsdp_serial_port.sv ----
// Summary of operation
// - Read flag returns addressed byte in readback
// - Reads fill readback lanes from MSB down
// - At most four reads per frame
// - Read limit two, three, four by length
// - Lanes C, D absent for short words
// - Any read forces readback word appended
// - Frame order AI AQ then BI BQ
// - Append pin forces readback every frame
// - Append pin, no read: zero word, late frame end
// - Read ignores command low data byte
// - One command per output I/Q word
// - Port select strap latched at reset release
// - Master select: own or external clocks
// - Sample input falling, outputs change rising
// - Frame sync sampled falling, shift next rising
// - Serial clock at most 32.5 MHz
// - First bit is AI MSB, then shift
// - Last bit belongs to final Q word, or to readback word when appended
// - Serial output released outside time slot
// - Frame sync ignored during active slot
// - Master frame sync one cycle before slot
// - Command: read, write, address, data byte
// - Write command stores byte to staging
// - Word length codes 16, 24, 32 bits
// - Frame end high during last bit
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

module fsdp_serial_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_select_strap,
  input wire logic clock_master_select,
  input wire logic readback_append,
  input wire logic command_serial_in,
  output logic sample_serial_out,
  output logic sample_serial_out_oe_n,
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe_n,
  input wire logic frame_sync_strobe_in,
  output logic frame_sync_strobe_out,
  output logic frame_sync_strobe_oe_n,
  output logic frame_end_strobe
);

  function automatic logic [31:0] fsdp_merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction : fsdp_merge

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [5:0] async_in;
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic strap_s, master_s, append_s, sdi_s, sclk_s, fs_s;

  assign async_in = {port_select_strap, clock_master_select, readback_append,
                     command_serial_in, serial_clock_in, frame_sync_strobe_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  assign {strap_s, master_s, append_s, sdi_s, sclk_s, fs_s} = sync2;

  //////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  logic [1:0] strap_cnt;
  logic strap_done, parallel_sel, serial_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      parallel_sel <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == fsdp_pkg::STRAP_WAIT) begin
        strap_done <= 1'b1;
        parallel_sel <= strap_s;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  assign serial_en = strap_done && !parallel_sel;

  //////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [31:0] ctrl, rd_mux, readback_last;
  logic [31:0] iq_word [4];
  logic pending, wr_en, go_wr, fs_issue, mapped, active, armed;
  logic [7:0] frame_cnt;
  logic [2:0] rd_cnt;
  logic [7:0] stage [8];

  assign wr_en = psel && penable && pwrite;
  assign go_wr = wr_en && paddr == fsdp_pkg::REG_FRAME_GO && pstrb[0]
                 && pwdata[0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      fsdp_pkg::REG_CTRL: rd_mux = ctrl;
      fsdp_pkg::REG_DATA_AI: rd_mux = iq_word[0];
      fsdp_pkg::REG_DATA_AQ: rd_mux = iq_word[1];
      fsdp_pkg::REG_DATA_BI: rd_mux = iq_word[2];
      fsdp_pkg::REG_DATA_BQ: rd_mux = iq_word[3];
      fsdp_pkg::REG_FRAME_GO: rd_mux = {31'h0000_0000, pending};
      fsdp_pkg::REG_STATUS: rd_mux = {16'h0000, frame_cnt, 1'b0, rd_cnt,
                                      serial_en, armed, pending, active};
      fsdp_pkg::REG_STAGE_LO: rd_mux = {stage[3], stage[2], stage[1], stage[0]};
      fsdp_pkg::REG_STAGE_HI: rd_mux = {stage[7], stage[6], stage[5], stage[4]};
      fsdp_pkg::REG_READBACK: rd_mux = readback_last;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= fsdp_pkg::CTRL_RESET;
      for (int i = 0; i < 4; i++) begin
        iq_word[i] <= fsdp_pkg::DATA_RESET;
      end
    end else if (wr_en) begin
      case (paddr)
        fsdp_pkg::REG_CTRL: ctrl <= fsdp_merge(ctrl, pwdata, pstrb);
        fsdp_pkg::REG_DATA_AI: iq_word[0] <= fsdp_merge(iq_word[0], pwdata, pstrb);
        fsdp_pkg::REG_DATA_AQ: iq_word[1] <= fsdp_merge(iq_word[1], pwdata, pstrb);
        fsdp_pkg::REG_DATA_BI: iq_word[2] <= fsdp_merge(iq_word[2], pwdata, pstrb);
        fsdp_pkg::REG_DATA_BQ: iq_word[3] <= fsdp_merge(iq_word[3], pwdata, pstrb);
        default: ;
      endcase
    end
  end

  // Frame request: a new request wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    end else if (go_wr) begin
      pending <= 1'b1;
    end else if (fs_issue) begin
      pending <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial clock: own divider or sampled external clock
  logic [3:0] sdiv, half, div_cnt;
  logic master_mode, div_tick, sclk_prev, sclk_rise, sclk_fall;

  assign master_mode = master_s && serial_en;
  assign sdiv = ctrl[fsdp_pkg::CTRL_SDIV_LSB +: 4];
  assign half = (sdiv < fsdp_pkg::HALF_MIN) ? fsdp_pkg::HALF_MIN : sdiv;
  assign div_tick = div_cnt == half - 4'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 4'h0;
      serial_clock_out <= 1'b0;
    end else if (!master_mode) begin
      div_cnt <= 4'h0;
      serial_clock_out <= 1'b0;
    end else if (div_tick) begin
      div_cnt <= 4'h0;
      serial_clock_out <= ~serial_clock_out;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  always_comb begin
    if (master_mode) begin
      sclk_rise = div_tick && !serial_clock_out;
      sclk_fall = div_tick && serial_clock_out;
    end else begin
      sclk_rise = serial_en && sclk_s && !sclk_prev;
      sclk_fall = serial_en && !sclk_s && sclk_prev;
    end
  end

  assign serial_clock_oe_n = !master_mode;
  assign frame_sync_strobe_oe_n = !master_mode;

  //////////////////////////////////////////////////////////////////////////
  // Master frame sync
  assign fs_issue = sclk_rise && master_mode && pending && !active && !armed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_strobe_out <= 1'b0;
    end else if (!master_mode) begin
      frame_sync_strobe_out <= 1'b0;
    end else if (sclk_rise) begin
      frame_sync_strobe_out <= fs_issue;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame shifter
  logic [1:0] wl_q;
  logic [5:0] wl_last, bit_cnt;
  logic [2:0] rd_max, iq_words, word_idx, next_idx;
  logic [31:0] shreg, rb, next_word;
  logic div_q, cur_rd, cur_wr, rb_want, last_word, fs_val;

  always_comb begin
    case (wl_q)
      fsdp_pkg::WL_16: begin
        wl_last = fsdp_pkg::WL_LAST_16;
        rd_max = fsdp_pkg::RD_MAX_16;
      end
      fsdp_pkg::WL_24: begin
        wl_last = fsdp_pkg::WL_LAST_24;
        rd_max = fsdp_pkg::RD_MAX_24;
      end
      default: begin
        wl_last = fsdp_pkg::WL_LAST_32;
        rd_max = fsdp_pkg::RD_MAX_32;
      end
    endcase
  end

  assign iq_words = div_q ? fsdp_pkg::IQ_WORDS_DIV
                          : fsdp_pkg::IQ_WORDS_SINGLE;
  assign rb_want = append_s || rd_cnt != 3'h0 || (cur_rd && !cur_wr);
  assign last_word = (word_idx == iq_words - 3'h1 && !rb_want)
                     || word_idx == iq_words;
  assign next_idx = word_idx + 3'h1;
  assign next_word = (next_idx == iq_words) ? rb : iq_word[next_idx[1:0]];
  assign fs_val = master_mode ? frame_sync_strobe_out : fs_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      active <= 1'b0;
      wl_q <= fsdp_pkg::WL_16;
      div_q <= 1'b0;
      word_idx <= 3'h0;
      bit_cnt <= 6'h00;
      shreg <= 32'h0000_0000;
      sample_serial_out <= 1'b0;
      sample_serial_out_oe_n <= 1'b1;
      frame_end_strobe <= 1'b0;
      frame_cnt <= 8'h00;
      readback_last <= 32'h0000_0000;
    end else if (!serial_en) begin
      armed <= 1'b0;
      active <= 1'b0;
      sample_serial_out_oe_n <= 1'b1;
      frame_end_strobe <= 1'b0;
    end else if (sclk_fall) begin
      if (!active && fs_val) begin
        armed <= 1'b1;
      end
    end else if (sclk_rise) begin
      frame_end_strobe <= 1'b0;
      if (armed) begin
        armed <= 1'b0;
        active <= 1'b1;
        wl_q <= ctrl[fsdp_pkg::CTRL_WL_LSB +: 2];
        div_q <= ctrl[fsdp_pkg::CTRL_DIV_BIT];
        word_idx <= 3'h0;
        bit_cnt <= 6'h00;
        shreg <= {iq_word[0][30:0], 1'b0};
        sample_serial_out <= iq_word[0][31];
        sample_serial_out_oe_n <= 1'b0;
        frame_cnt <= frame_cnt + 8'h01;
      end else if (active) begin
        if (bit_cnt == wl_last) begin
          if (last_word) begin
            active <= 1'b0;
            sample_serial_out <= 1'b0;
            sample_serial_out_oe_n <= 1'b1;
          end else begin
            word_idx <= next_idx;
            bit_cnt <= 6'h00;
            shreg <= {next_word[30:0], 1'b0};
            sample_serial_out <= next_word[31];
            if (next_idx == iq_words) begin
              readback_last <= rb;
            end
          end
        end else begin
          bit_cnt <= bit_cnt + 6'h01;
          shreg <= {shreg[30:0], 1'b0};
          sample_serial_out <= shreg[31];
          frame_end_strobe <= (bit_cnt + 6'h01 == wl_last) && last_word;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command capture and readback assembly
  logic [14:0] cmd_sh;
  logic [15:0] cmd;
  logic [2:0] cmd_addr;

  assign cmd = {cmd_sh, sdi_s};
  assign cmd_addr = cmd[fsdp_pkg::CMD_ADDR_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_sh <= 15'h0000;
      cur_rd <= 1'b0;
      cur_wr <= 1'b0;
      rd_cnt <= 3'h0;
      rb <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
        stage[i] <= 8'h00;
      end
    end else if (sclk_rise && armed && serial_en) begin
      rd_cnt <= 3'h0;
      rb <= 32'h0000_0000;
      cur_rd <= 1'b0;
      cur_wr <= 1'b0;
    end else if (sclk_fall && active && word_idx < iq_words) begin
      if (bit_cnt <= fsdp_pkg::CMD_BIT_LAST) begin
        cmd_sh <= {cmd_sh[13:0], sdi_s};
      end
      if (bit_cnt == fsdp_pkg::CMD_BIT_READ) begin
        cur_rd <= sdi_s;
      end
      if (bit_cnt == fsdp_pkg::CMD_BIT_WRITE) begin
        cur_wr <= sdi_s;
      end
      if (bit_cnt == fsdp_pkg::CMD_BIT_LAST) begin
        if (cmd[fsdp_pkg::CMD_READ_BIT] && !cmd[fsdp_pkg::CMD_WRITE_BIT]) begin
          if (rd_cnt < rd_max) begin
            rd_cnt <= rd_cnt + 3'h1;
            case (rd_cnt)
              3'h0: rb[31:24] <= stage[cmd_addr];
              3'h1: rb[23:16] <= stage[cmd_addr];
              3'h2: rb[15:8] <= stage[cmd_addr];
              default: rb[7:0] <= stage[cmd_addr];
            endcase
          end
        end else if (cmd[fsdp_pkg::CMD_WRITE_BIT]
                     && !cmd[fsdp_pkg::CMD_READ_BIT]) begin
          stage[cmd_addr] <= cmd[7:0];
        end
        // Both flags set: no access
      end
    end
  end

endmodule : fsdp_serial_port

// ---- verification/fsdp_serial_port_monitor.sv ----
`timescale 1ns/1ps
module fsdp_serial_port_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic port_select_strap,
  input wire logic clock_master_select,
  input wire logic sample_serial_out,
  input wire logic sample_serial_out_oe_n,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe_n,
  input wire logic frame_sync_strobe_out,
  input wire logic frame_end_strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mst;
  assign mst = !serial_clock_oe_n;
  //////////////////////////////////////////////////////////////////////////
  sequence s_rise;
    mst && $rose(serial_clock_out);
  endsequence
  property p_rdy;
    psel && penable |-> pready
      && (pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0));
  endproperty
  property p_oe_end;
    $rose(sample_serial_out_oe_n) |-> $past(frame_end_strobe);
  endproperty
  property p_fe_slot;
    frame_end_strobe |-> !sample_serial_out_oe_n;
  endproperty
  property p_out_edge;
    mst && !sample_serial_out_oe_n && $changed(sample_serial_out) |-> s_rise;
  endproperty
  property p_fe_edge;
    mst && $rose(frame_end_strobe) |-> s_rise;
  endproperty
  property p_fs_start;
    mst && $fell(frame_sync_strobe_out) |->
      s_rise ##0 $fell(sample_serial_out_oe_n);
  endproperty
  property p_fs_quiet;
    !sample_serial_out_oe_n |-> !frame_sync_strobe_out;
  endproperty
  property p_half;
    s_rise |=> serial_clock_out[*3];
  endproperty
  property p_master;
    $fell(serial_clock_oe_n) |-> clock_master_select && !port_select_strap;
  endproperty
  //////////////////////////////////////////////////////////////////////////
  a_rdy: assert property (p_rdy) else $error("bad ready or error flag");
  a_oe_end: assert property (p_oe_end)
    else $error("output released before frame end");
  a_fe_slot: assert property (p_fe_slot)
    else $error("frame end outside slot");
  a_out_edge: assert property (p_out_edge)
    else $error("data changed off rising clock");
  a_fe_edge: assert property (p_fe_edge)
    else $error("frame end off rising clock");
  a_fs_start: assert property (p_fs_start)
    else $error("slot did not follow sync pulse");
  a_fs_quiet: assert property (p_fs_quiet)
    else $error("sync raised inside slot");
  a_half: assert property (p_half)
    else $error("serial clock high phase too short");
  a_master: assert property (p_master)
    else $error("clock driven while not master");
endmodule : fsdp_serial_port_monitor

bind fsdp_serial_port fsdp_serial_port_monitor i_mon (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .port_select_strap(port_select_strap),
  .clock_master_select(clock_master_select),
  .sample_serial_out(sample_serial_out),
  .sample_serial_out_oe_n(sample_serial_out_oe_n),
  .serial_clock_out(serial_clock_out), .serial_clock_oe_n(serial_clock_oe_n),
  .frame_sync_strobe_out(frame_sync_strobe_out),
  .frame_end_strobe(frame_end_strobe));

// ---- verification/fsdp_host_model.sv ----
`timescale 1ns/1ps
module fsdp_host_model (
  input wire logic sclk,
  input wire logic fs,
  input wire logic data_in,
  input wire logic data_oe_n,
  input wire logic go,
  input wire logic [5:0] wbits,
  input wire logic [63:0] cmds,
  input wire logic [7:0] nbits,
  output logic sclk_ext,
  output logic fs_ext,
  output logic cmd_out,
  output logic [159:0] cap,
  output logic [7:0] ncap
);
  logic act = 1'b0;
  int k = 0;
  initial begin
    sclk_ext = 1'b0;
    fs_ext = 1'b0;
    cmd_out = 1'b0;
    cap = '0;
    ncap = 8'h00;
  end
  // Cascade clock runs only for one frame; sync repeated inside the slot
  always @(posedge go) begin
    for (int i = 0; i < nbits + 3; i++) begin
      #32 sclk_ext = 1'b1;
      fs_ext = (i == 0 || i == 5);
      #32 sclk_ext = 1'b0;
    end
  end
  always @(negedge sclk) begin
    if (!data_oe_n) begin
      cap = {cap[158:0], data_in};
      ncap = ncap + 8'h01;
    end
    if (fs && !act) begin
      act = 1'b1;
      k = 0;
      cap = '0;
      ncap = 8'h00;
    end
  end
  // One command word per output word, 16 bits then padding
  always @(posedge sclk) begin
    if (act) begin
      cmd_out = (k % wbits < 16 && k / wbits < 4) ?
        cmds[63 - 16 * (k / wbits) - k % wbits] : 1'b0;
      k = k + 1;
      if (k >= nbits) act = 1'b0;
    end
  end
endmodule : fsdp_host_model

// ---- verification/fsdp_serial_port_tb_top.sv ----
`timescale 1ns/1ps
module fsdp_serial_port_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, nbits, ncap;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic port_select_strap, clock_master_select, readback_append;
  logic command_serial_in, sample_serial_out, sample_serial_out_oe_n;
  logic serial_clock_out, serial_clock_oe_n, frame_sync_strobe_out;
  logic frame_sync_strobe_oe_n, frame_end_strobe, sclk_ext, fs_ext;
  logic sclk_w, fs_w, go;
  logic [5:0] wbits;
  logic [63:0] cmds;
  logic [159:0] cap;
  logic [31:0] dat [4] = '{32'h9A5C3E71, 32'h1234ABCD, 32'hF00F5AA5,
    32'h6C39E4D2};
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  assign sclk_w = serial_clock_oe_n ? sclk_ext : serial_clock_out;
  assign fs_w = frame_sync_strobe_oe_n ? fs_ext : frame_sync_strobe_out;
  fsdp_serial_port i_fsdp_serial_port (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_select_strap(port_select_strap),
    .clock_master_select(clock_master_select),
    .readback_append(readback_append), .command_serial_in(command_serial_in),
    .sample_serial_out(sample_serial_out),
    .sample_serial_out_oe_n(sample_serial_out_oe_n),
    .serial_clock_in(sclk_w), .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(serial_clock_oe_n), .frame_sync_strobe_in(fs_w),
    .frame_sync_strobe_out(frame_sync_strobe_out),
    .frame_sync_strobe_oe_n(frame_sync_strobe_oe_n),
    .frame_end_strobe(frame_end_strobe));
  fsdp_host_model i_fsdp_host_model (.sclk(sclk_w), .fs(fs_w),
    .data_in(sample_serial_out), .data_oe_n(sample_serial_out_oe_n),
    .go(go), .wbits(wbits), .cmds(cmds), .nbits(nbits), .sclk_ext(sclk_ext),
    .fs_ext(fs_ext), .cmd_out(command_serial_in), .cap(cap), .ncap(ncap));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [159:0] got, input logic [159:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [159:0] add(input logic [159:0] e,
    input logic [31:0] d);
    return (e << wbits) | 160'(d >> (6'd32 - wbits));
  endfunction : add
  function automatic logic [159:0] iq(input int nw);
    iq = '0;
    for (int j = 0; j < nw; j++) iq = add(iq, dat[j]);
  endfunction : iq
  task automatic cfg(input logic [1:0] code, input logic dv);
    apb(1'b1, fsdp_pkg::REG_CTRL, {29'h0, dv, code});
    wbits = 6'h10 + {1'b0, code, 3'h0};
  endtask : cfg
  task automatic frame(input logic [63:0] c, input logic [159:0] e,
    input logic [7:0] n);
    cmds <= c;
    nbits <= n;
    if (clock_master_select) apb(1'b1, fsdp_pkg::REG_FRAME_GO, 32'h1);
    else begin
      @(posedge pclk);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
    end
    for (int i = 0; i < 9000 && frame_end_strobe !== 1'b1; i++)
      @(posedge pclk);
    for (int i = 0; i < 9000 && frame_end_strobe !== 1'b0; i++)
      @(posedge pclk);
    repeat (60) @(posedge pclk);
    chk(cap, e);
    chk(160'(ncap), 160'(n));
  endtask : frame
  task automatic stage(input logic [31:0] e);
    apb(1'b0, fsdp_pkg::REG_STAGE_LO, 32'h0);
    chk(160'(rdat & 32'h00FFFF00), 160'(e));
  endtask : stage
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, fsdp_pkg::REG_CTRL, 32'h0);
    chk(160'(rdat), 160'(fsdp_pkg::CTRL_RESET));
    apb(1'b0, 8'h40, 32'h0);
    chk(160'({rerr, rdat}), 160'({1'b1, 32'h0}));
    for (int j = 0; j < 4; j++)
      apb(1'b1, fsdp_pkg::REG_DATA_AI + 8'(4 * j), dat[j]);
  endtask : t_regs
  task automatic t_plain;
    cfg(fsdp_pkg::WL_16, 1'b0);
    frame(64'h0, iq(2), 8'd32);
  endtask : t_plain
  task automatic t_rw;
    cfg(fsdp_pkg::WL_16, 1'b1);
    frame(64'h415A_423C_81FF_8200, add(iq(4), 32'h5A3C0000), 8'd80);
    stage(32'h003C5A00);
    apb(1'b0, fsdp_pkg::REG_READBACK, 32'h0);
    chk(160'(rdat), 160'(32'h5A3C0000));
    apb(1'b0, fsdp_pkg::REG_STATUS, 32'h0);
    chk(160'(rdat), 160'(32'h0000_0228));
  endtask : t_rw
  task automatic t_limit;
    frame(64'h8200_8100_8200_C1EE, add(iq(4), 32'h3C5A0000), 8'd80);
    stage(32'h003C5A00);
  endtask : t_limit
  task automatic t_three;
    cfg(fsdp_pkg::WL_24, 1'b1);
    frame(64'h8100_8200_8200_8100, add(iq(4), 32'h5A3C3C00), 8'd120);
  endtask : t_three
  task automatic t_append;
    readback_append <= 1'b1;
    cfg(fsdp_pkg::WL_24, 1'b0);
    frame(64'h0, add(iq(2), 32'h0), 8'd72);
    readback_append <= 1'b0;
  endtask : t_append
  task automatic t_slave;
    clock_master_select <= 1'b0;
    repeat (10) @(posedge pclk);
    cfg(fsdp_pkg::WL_32, 1'b1);
    frame(64'h8100_8200_8100_8200, add(iq(4), 32'h5A3C5A3C), 8'd160);
  endtask : t_slave
  task automatic t_strap;
    presetn <= 1'b0;
    port_select_strap <= 1'b1;
    clock_master_select <= 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b1, fsdp_pkg::REG_FRAME_GO, 32'h1);
    repeat (100) @(posedge pclk);
    chk(160'({sample_serial_out_oe_n, frame_end_strobe}), 160'(2'h2));
  endtask : t_strap
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    port_select_strap = 1'b0;
    clock_master_select = 1'b1;
    readback_append = 1'b0;
    go = 1'b0;
    cmds = 64'h0;
    nbits = 8'h00;
    wbits = 6'h10;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_regs();
    t_plain();
    t_rw();
    t_limit();
    t_three();
    t_append();
    t_slave();
    t_strap();
    close_out();
  end
endmodule : fsdp_serial_port_tb_top
